//--- hdl/dfa_map.svh
// Register offsets, field positions, reset values and trims of the
// FIFO alignment control block.
// Assumes inclusion by its bare name from the block's design files.
`ifndef DFA_MAP_SVH
`define DFA_MAP_SVH

`define DFA_ADDR_ALIGN_CTRL  12'h220
`define DFA_ADDR_LAT3        12'h213
`define DFA_ALIGN_CTRL_RESET 8'h00
`define DFA_LAT3_RESET       5'h00
`define DFA_BIT_SYSREF_EN    0
`define DFA_BIT_STROBE_TRIG  1
`define DFA_LAT_TRIM_MODE0   6'h03
`define DFA_LAT_TRIM_OTHER   6'h01

`endif

//--- hdl/dfa_pkg.sv
// Types shared by the FIFO alignment control block.
// Assumes nothing of its surroundings.
`default_nettype none

package dfa_pkg;

  // Gray coded along idle, run, done.
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_RUN  = 2'b01,
    MEAS_DONE = 2'b11
  } dfa_meas_state_type;

endpackage

`default_nettype wire

//--- hdl/dfa_edge_sync.sv
// Two-flop synchroniser for one asynchronous pin with rising edge detect.
// Assumes the pin is held at least two clock periods per level.
`default_nettype none

module dfa_edge_sync (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;

endmodule

`default_nettype wire

//--- hdl/dfa_align.sv
// FIFO alignment control between the LVDS receive side and the DAC clock.
// Assumes a register port driven on the DAC clock, pins sysref and the
// two LVDS bank clocks asynchronous, all other inputs on the DAC clock.
//
// Behaviour
// - Read-only five-bit field reports FIFO 3 start delay matching arrival.
// - Value is DAC clocks sysref-to-first-sample minus 3 (mode 0) or 1.
// - Writing one to the trigger bit while it is zero realigns once.
// - Strobe alignment references bank 0 when in use, else bank 2.
// - Alignment to the LVDS receiver never repeats on its own.
// - A strobe alignment that moves the FIFO raises realigned alarm.
// - Strobe alignment uses the receiver's present phase, no strobe wait.
// - After sysref sync, trigger ignored until reset or datapath off.
// - With sysref realign enabled, every sysref edge realigns the FIFO.
// - Misaligned sysref edge while enabled raises realigned alarm, realigns.
// - With sysref realign disabled, sysref edges leave alignment alone.
// - Every misaligned sysref edge raises the misalign alarm.
// - A sysref edge near the enable write may be taken either way.
// - Start delay gives DAC clocks from sysref to expected first read.
`include "dfa_map.svh"
`default_nettype none

module dfa_align #(
  parameter int PHASE_W = 3
) (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                reg_wr_en,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [7:0]          reg_wr_data,
  output logic      [7:0]          reg_rd_data,
  input  wire logic                sysref,
  input  wire logic                lvds_clk_bank0,
  input  wire logic                lvds_clk_bank2,
  input  wire logic                bank0_in_use,
  input  wire logic                lvds_mode_zero,
  input  wire logic                datapath_enable,
  input  wire logic                first_sample,
  input  wire logic [4:0]          fifo_start_delay,
  input  wire logic                realigned_clear,
  input  wire logic                misalign_clear,
  output logic                     clock_realigned_alarm,
  output logic                     clock_misalign_alarm,
  output logic [PHASE_W-1:0]       read_phase,
  output logic                     read_start,
  output var dfa_pkg::dfa_meas_state_type meas_state
);
  import dfa_pkg::*;

  logic [2:0] pin_rise;
  wire  [2:0] pin_async = {lvds_clk_bank2, lvds_clk_bank0, sysref};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      dfa_edge_sync u_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in (pin_async[gi]),
        .level    (),
        .rise     (pin_rise[gi])
      );
    end
  endgenerate

  logic [7:0]         ctrl_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  logic [PHASE_W-1:0] bank_phase_reg [2];
  logic               synced_reg;
  logic               realigned_reg;
  logic               misalign_reg;
  logic [5:0]         meas_cnt_reg;
  logic [4:0]         lat3_reg;
  logic [7:0]         rd_data_reg;
  logic               start_reg;
  dfa_meas_state_type meas_reg;
  dfa_meas_state_type meas_next;

  // Each bank's receiver phase is the read phase at its latest clock edge.
  always_ff @(posedge clock) begin
    if (srst) begin
      bank_phase_reg[0] <= '0;
      bank_phase_reg[1] <= '0;
    end else begin
      if (pin_rise[1]) bank_phase_reg[0] <= phase_reg;
      if (pin_rise[2]) bank_phase_reg[1] <= phase_reg;
    end
  end

  wire ctrl_wr   = reg_wr_en && (reg_addr == `DFA_ADDR_ALIGN_CTRL);
  wire sysref_en = ctrl_reg[`DFA_BIT_SYSREF_EN];
  // Only the zero-to-one write of the trigger acts, so the FIFO is never
  // pulled again by the drifting asynchronous LVDS clock.
  wire trig_write = ctrl_wr && reg_wr_data[`DFA_BIT_STROBE_TRIG]
                    && !ctrl_reg[`DFA_BIT_STROBE_TRIG];
  wire strobe_go  = trig_write && !synced_reg;
  wire [PHASE_W-1:0] ref_phase =
    bank0_in_use ? bank_phase_reg[0] : bank_phase_reg[1];
  wire strobe_moves = strobe_go && (ref_phase != '0);
  wire sysref_rise  = pin_rise[0];
  wire sysref_miss  = sysref_rise && (phase_reg != '0);
  // The enable is sampled in the same cycle as the synchronised edge, so an
  // edge landing close to the enable write may be taken or not.
  wire sysref_go    = sysref_rise && sysref_en;

  always_comb begin
    phase_next = phase_reg + 1'b1;
    if (sysref_go) begin
      phase_next = PHASE_W'(1);
    end else if (strobe_go) begin
      phase_next = PHASE_W'(phase_reg - ref_phase + 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_reg  <= `DFA_ALIGN_CTRL_RESET;
      phase_reg <= '0;
    end else begin
      if (ctrl_wr) ctrl_reg <= reg_wr_data;
      phase_reg <= phase_next;
    end
  end

  // Once sysref has aligned the system, the strobe trigger is locked out.
  always_ff @(posedge clock) begin
    if (srst || !datapath_enable) begin
      synced_reg <= 1'b0;
    end else if (sysref_go) begin
      synced_reg <= 1'b1;
    end
  end

  // Sticky alarms: a new event in the clearing cycle wins.
  always_ff @(posedge clock) begin
    if (srst) begin
      realigned_reg <= 1'b0;
      misalign_reg  <= 1'b0;
    end else begin
      if (strobe_moves || (sysref_go && sysref_miss)) begin
        realigned_reg <= 1'b1;
      end else if (realigned_clear) begin
        realigned_reg <= 1'b0;
      end
      if (sysref_miss) begin
        misalign_reg <= 1'b1;
      end else if (misalign_clear) begin
        misalign_reg <= 1'b0;
      end
    end
  end

  // Latency from any synchronised sysref edge while the datapath is enabled, sysref realign on or off, to the first sample.
  wire [5:0] lat_trim = lvds_mode_zero ? `DFA_LAT_TRIM_MODE0
                                       : `DFA_LAT_TRIM_OTHER;
  wire [5:0] lat_raw  = (meas_cnt_reg > lat_trim) ? 6'(meas_cnt_reg - lat_trim)
                                                  : 6'h00;
  wire [4:0] lat_sat  = lat_raw[5] ? 5'h1f : lat_raw[4:0];
  wire meas_begin = sysref_rise && datapath_enable;
  wire meas_stop  = (meas_reg == MEAS_RUN) && first_sample;
  wire start_hit  = (meas_reg == MEAS_RUN)
                    && (meas_cnt_reg == {1'b0, fifo_start_delay});

  always_comb begin
    meas_next = meas_reg;
    unique case (meas_reg)
      MEAS_IDLE: if (meas_begin) meas_next = MEAS_RUN;
      MEAS_RUN:  if (meas_stop) meas_next = MEAS_DONE;
      MEAS_DONE: if (meas_begin) meas_next = MEAS_RUN;
      default:   meas_next = MEAS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meas_reg     <= MEAS_IDLE;
      meas_cnt_reg <= '0;
      lat3_reg     <= `DFA_LAT3_RESET;
      start_reg    <= 1'b0;
    end else begin
      meas_reg  <= meas_next;
      start_reg <= start_hit;
      if (meas_begin) begin
        meas_cnt_reg <= '0;
      end else if (meas_reg == MEAS_RUN && meas_cnt_reg != 6'h3f) begin
        meas_cnt_reg <= meas_cnt_reg + 1'b1;
      end
      if (meas_stop) lat3_reg <= lat_sat;
    end
  end

  // Register reads; unmapped addresses return zero.
  wire [7:0] rd_mux = (reg_addr == `DFA_ADDR_ALIGN_CTRL) ? ctrl_reg :
                      (reg_addr == `DFA_ADDR_LAT3) ? {3'h0, lat3_reg} :
                      8'h00;

  always_ff @(posedge clock) begin
    if (srst) rd_data_reg <= 8'h00;
    else      rd_data_reg <= rd_mux;
  end

  assign reg_rd_data           = rd_data_reg;
  assign clock_realigned_alarm = realigned_reg;
  assign clock_misalign_alarm  = misalign_reg;
  assign read_phase            = phase_reg;
  assign read_start            = start_reg;
  assign meas_state            = meas_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_trig_phase: assert property (
    strobe_go && !sysref_go && bank0_in_use |=>
      phase_reg == PHASE_W'($past(phase_reg) - $past(bank_phase_reg[0]) + 1))
    else $error("strobe trigger did not realign phase");
  a_bank_two_ref: assert property (
    strobe_go && !sysref_go && !bank0_in_use |=>
      phase_reg == PHASE_W'($past(phase_reg) - $past(bank_phase_reg[1]) + 1))
    else $error("bank 2 not used as reference");
  a_no_repeat: assert property (
    strobe_go |=> !strobe_go)
    else $error("strobe alignment repeated");
  a_strobe_alarm: assert property (
    strobe_moves |=> realigned_reg)
    else $error("moved alignment without realigned alarm");
  a_locked_out: assert property (
    synced_reg && trig_write && !sysref_go |=>
      phase_reg == PHASE_W'($past(phase_reg) + 1))
    else $error("trigger acted after sysref sync");
  a_sysref_realign: assert property (
    sysref_go && sysref_miss |=> phase_reg == PHASE_W'(1) && realigned_reg)
    else $error("sysref edge did not realign");
  a_sysref_hold: assert property (
    sysref_rise && !sysref_en && !strobe_go |=>
      phase_reg == PHASE_W'($past(phase_reg) + 1))
    else $error("disabled sysref moved alignment");
  a_misalign_flag: assert property (
    sysref_miss |=> misalign_reg)
    else $error("misaligned sysref not flagged");
  a_alarm_sticky: assert property (
    realigned_reg && !realigned_clear |=> realigned_reg)
    else $error("realigned alarm dropped without clear");
  a_latency_value: assert property (
    meas_stop && meas_cnt_reg > 6'h03 && meas_cnt_reg < 6'h20 |=>
      lat3_reg == 5'($past(meas_cnt_reg) - ($past(lvds_mode_zero)
        ? `DFA_LAT_TRIM_MODE0 : `DFA_LAT_TRIM_OTHER))
      && meas_reg == MEAS_DONE)
    else $error("latency readback wrong");
  a_start_pulse: assert property (
    start_reg |-> $past(meas_cnt_reg) == {1'b0, $past(fifo_start_delay)})
    else $error("read start at wrong delay");

  c_strobe_align: cover property (strobe_moves);
  c_sysref_realign: cover property (sysref_go && sysref_miss);
  c_latency_done: cover property (meas_stop);

endmodule

`default_nettype wire

//--- bench/dfa_fpga_model.sv
// FPGA side model: drives the two LVDS bank clocks at a 32 ns period.
// Assumes the bench sets run and the skews in whole nanoseconds.
`default_nettype none

module dfa_fpga_model (
  input  wire logic       run,
  input  wire logic [7:0] skew0,
  input  wire logic [7:0] skew2,
  output logic            lvds_clk_bank0,
  output logic            lvds_clk_bank2
);
  timeunit 1ns;
  timeprecision 1ps;
  int t;
  // The clocks stand low while run is off. Odd skews keep every edge
  // away from the DAC clock edge, so sampling never races.
  initial begin
    t = 0;
    lvds_clk_bank0 = 1'b0;
    lvds_clk_bank2 = 1'b0;
    forever begin
      #1;
      t = t + 1;
      lvds_clk_bank0 = run && ((t + skew0) % 32 < 16);
      lvds_clk_bank2 = run && ((t + skew2) % 32 < 16);
    end
  end
endmodule

`default_nettype wire

//--- bench/dfa_align_tb_top.sv
// Bench for the FIFO alignment block: register access, strobe alignment
// against the FPGA model, sysref sequences and latency readback.
// Assumes the design files and the FPGA model are compiled before it.
`include "dfa_map.svh"
`default_nettype none

module dfa_align_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, srst, reg_wr_en, sysref, first_sample, run;
  logic        bank0_in_use, lvds_mode_zero, datapath_enable;
  logic        realigned_clear, misalign_clear;
  logic        clock_realigned_alarm, clock_misalign_alarm;
  logic        lvds_clk_bank0, lvds_clk_bank2;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wr_data, reg_rd_data, skew0, skew2;
  logic [2:0]  read_phase;
  logic        read_start;
  logic [4:0]  start_delay;
  dfa_pkg::dfa_meas_state_type meas_state;
  int          start_at = 0;
  int          fail_count = 0;
  int          num_checks = 0;

  dfa_align dfa_align_i (
    .clock, .srst, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data,
    .sysref, .lvds_clk_bank0, .lvds_clk_bank2, .bank0_in_use,
    .lvds_mode_zero, .datapath_enable, .first_sample,
    .fifo_start_delay(start_delay), .realigned_clear, .misalign_clear,
    .clock_realigned_alarm, .clock_misalign_alarm,
    .read_phase, .read_start, .meas_state
  );
  dfa_fpga_model dfa_fpga_model_i (
    .run, .skew0, .skew2, .lvds_clk_bank0, .lvds_clk_bank2
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    step(1);
    reg_wr_en = 1'b0;
    reg_addr = `DFA_ADDR_LAT3;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    step(1);
    reg_addr = a;
    step(2);
    chk("reg_rd_data", reg_rd_data, e);
  endtask

  task automatic al(input logic re, mi);
    chk("realigned", {7'h00, clock_realigned_alarm}, {7'h00, re});
    chk("misalign", {7'h00, clock_misalign_alarm}, {7'h00, mi});
  endtask

  task automatic clr;
    realigned_clear = 1'b1;
    misalign_clear = 1'b1;
    step(1);
    realigned_clear = 1'b0;
    misalign_clear = 1'b0;
  endtask

  // The wait first lets a bank clock edge refresh the phase reference.
  task automatic trig;
    step(12);
    wr(`DFA_ADDR_ALIGN_CTRL, 8'h00);
    step(1);
    wr(`DFA_ADDR_ALIGN_CTRL, 8'h02);
    step(2);
  endtask

  // One sysref pulse, with the control write in its first cycle; the
  // next pulse starts gap cycles later, so phases stay known.
  task automatic sp(input int gap, input logic c, input logic [7:0] ctl,
                    input int fs);
    start_at = 0;
    sysref = 1'b1;
    realigned_clear = c;
    misalign_clear = c;
    wr(`DFA_ADDR_ALIGN_CTRL, ctl);
    realigned_clear = 1'b0;
    misalign_clear = 1'b0;
    for (int i = 1; i < gap; i++) begin
      sysref = (i < 4);
      first_sample = (i == fs);
      step(1);
      if (read_start === 1'b1) start_at = i;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    give_verdict();
  end

  initial begin
    {srst, datapath_enable, bank0_in_use, lvds_mode_zero} = 4'hf;
    {reg_wr_en, sysref, first_sample, run} = 4'h0;
    {realigned_clear, misalign_clear} = 2'h0;
    reg_addr = `DFA_ADDR_LAT3;
    reg_wr_data = 8'h00;
    skew0 = 8'h01;
    skew2 = 8'h0d;
    start_delay = 5'h04;
    step(12);
    srst = 1'b0;
    rd(`DFA_ADDR_LAT3, 8'(`DFA_LAT3_RESET));
    rd(`DFA_ADDR_ALIGN_CTRL, `DFA_ALIGN_CTRL_RESET);
    wr(`DFA_ADDR_LAT3, 8'hff);
    rd(`DFA_ADDR_LAT3, 8'h00);
    rd(12'h221, 8'h00);
    wr(`DFA_ADDR_ALIGN_CTRL, 8'hfc);
    rd(`DFA_ADDR_ALIGN_CTRL, 8'hfc);
    run = 1'b1;
    trig();
    clr();
    trig();
    al(1'b0, 1'b0);
    skew0 = 8'h05;
    step(40);
    al(1'b0, 1'b0);
    trig();
    al(1'b1, 1'b0);
    clr();
    bank0_in_use = 1'b0;
    trig();
    al(1'b1, 1'b0);
    clr();
    trig();
    al(1'b0, 1'b0);
    bank0_in_use = 1'b1;
    run = 1'b0;
    trig();
    al(1'b1, 1'b0);
    run = 1'b1;
    sp(16, 1'b1, 8'h01, 0);
    sp(19, 1'b1, 8'h01, 12);
    al(1'b0, 1'b0);
    chk("lat3", reg_rd_data, 8'(12 - 3 - `DFA_LAT_TRIM_MODE0));
    chk("start", 8'(start_at), 8'h07);
    chk("meas", {6'h00, meas_state}, 8'(dfa_pkg::MEAS_DONE));
    sp(16, 1'b1, 8'h01, 0);
    al(1'b1, 1'b1);
    chk("phase", {5'h00, read_phase}, 8'h06);
    chk("meas", {6'h00, meas_state}, 8'(dfa_pkg::MEAS_RUN));
    lvds_mode_zero = 1'b0;
    start_delay = 5'h06;
    sp(19, 1'b0, 8'h00, 12);
    al(1'b1, 1'b1);
    chk("lat3", reg_rd_data, 8'(12 - 3 - `DFA_LAT_TRIM_OTHER));
    chk("start", 8'(start_at), 8'h09);
    sp(16, 1'b1, 8'h00, 0);
    al(1'b0, 1'b1);
    sp(16, 1'b1, 8'h00, 0);
    al(1'b0, 1'b1);
    chk("phase", {5'h00, read_phase}, 8'h01);
    trig();
    skew0 = 8'h15;
    step(40);
    trig();
    al(1'b0, 1'b1);
    datapath_enable = 1'b0;
    step(2);
    datapath_enable = 1'b1;
    trig();
    skew0 = 8'h05;
    step(40);
    trig();
    al(1'b1, 1'b1);
    give_verdict();
  end
endmodule

`default_nettype wire
